// >>> tap_port_pkg.sv
// shared constants, types and register map for the boundary-scan test port
package tap_port_pkg;

  // instruction chain
  localparam int IR_WIDTH = 5;
  localparam logic [4:0] IR_CAPTURE = 5'h01;
  localparam logic [4:0] IR_EXTEST = 5'h00;
  localparam logic [4:0] IR_SAMPLE = 5'h02;
  localparam logic [4:0] IR_PRIV_BSR = 5'h03;
  localparam logic [4:0] IR_CLAMP = 5'h04;
  localparam logic [4:0] IR_HIGHZ = 5'h05;
  localparam logic [4:0] IR_ID_A = 5'h06;
  localparam logic [4:0] IR_ID_B = 5'h07;
  localparam logic [4:0] IR_BYPASS = 5'h1f;

  // boundary chain layout
  localparam int BSR_LEN = 289;
  localparam int GROUPS = 7;
  localparam int SNIFFER_POS = 255;
  localparam int GROUP_CTRL_POS [GROUPS] = '{288, 245, 226, 109, 101, 97, 72};
  localparam int LOW_WORD_TOP = 225;
  localparam int LOW_WORD_BOT = 154;
  localparam int HIGH_WORD_TOP = 71;
  localparam int ID_LEN = 32;
  localparam logic [31:0] ID_VALUE = 32'h0000_0a51; // arbitrary value

  // tap sequencing
  localparam int TLR_ONES = 5;

  // status pin timing
  localparam int PULSE_CYCLES = 256;
  localparam int TIMEOUT_CYCLES = 1000000000;
  localparam int SYSCLK_DIV = 4;

  // apb register map
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam int CTRL_STATUS1_BIT = 0;
  localparam int STAT_SELFTEST_BIT = 0;
  localparam int STAT_PULSE_BIT = 1;
  localparam int STAT_ENABLE_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_IR_LSB = 8;

  typedef enum logic [3:0] {
    st_reset, st_idle, st_sel_dr, st_cap_dr, st_shift_dr, st_exit1_dr, st_pause_dr,
    st_exit2_dr, st_upd_dr, st_sel_ir, st_cap_ir, st_shift_ir, st_exit1_ir, st_pause_ir,
    st_exit2_ir, st_upd_ir
  } tap_state_type;

  // test port pins as seen at the pads
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
    logic trst_n;
  } tap_pins_type;

endpackage : tap_port_pkg

// >>> boundary_scan_test_port.sv
// boundary-scan test access port with test status pins and apb register access
// Functional notes
// RL1: five-bit instruction chain decodes public codes
// RL2: capture-ir loads pattern 00001
// RL3: extest selects boundary chain, cells drive pins
// RL4: sample/preload selects boundary chain, pins untouched
// RL5: clamp selects skip chain, cells drive pins
// RL6: highz floats all outputs, selects skip chain
// RL7: bypass is default; 00110/00111 select identification
// RL8: skip chain is one stage
// RL9: boundary chain has 289 cells when selected
// RL10: shift from cell 288 toward cell 0
// RL11: seven groups, control 1 tristates group
// RL12: control cells at 288,245,226,109,101,97,72
// RL13: cell 255 captures oscillator presence
// RL14: oscillator pins have no cells
// RL15: tap machine makes capture, shift, update controls
// RL16: data words at cells 225-154 and 71-0
// RL17: system reset drives both status pins low
// RL18: self-test pin high at start, low on pass
// RL19: software writes status1 and reads status0
// RL20: timeout on retire stall or fail without ack
// RL21: timeout gives 256-cycle pulse on sysclk edges; code ends it on the first tick after 256 cycles
// RL22: tester holds port mode 00, power good 1
// RL23: test reset input pulled down, holds reset
// RL24: sixteen states; five tms ones reach reset
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ps
module boundary_scan_test_port #(
  parameter int TIMEOUT_CYCLES = tap_port_pkg::TIMEOUT_CYCLES,
  parameter int SYSCLK_DIV = tap_port_pkg::SYSCLK_DIV,
  parameter logic [31:0] ID_VALUE = tap_port_pkg::ID_VALUE
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire tap_port_pkg::tap_pins_type tap_pins,
  output logic tdo,
  output logic tdo_oe,
  input wire logic [1:0] port_mode,
  input wire logic power_good_input,
  input wire logic osc_present,
  input wire logic [tap_port_pkg::BSR_LEN-1:0] pin_in,
  input wire logic [tap_port_pkg::BSR_LEN-1:0] core_out,
  input wire logic [tap_port_pkg::GROUPS-1:0] core_group_oe,
  output logic [tap_port_pkg::BSR_LEN-1:0] pin_out,
  output logic [tap_port_pkg::GROUPS-1:0] group_oe,
  output logic outputs_oe,
  input wire logic sys_reset_n,
  input wire logic selftest_start,
  input wire logic selftest_done,
  input wire logic selftest_pass,
  input wire logic retire,
  input wire logic cmd_fail,
  input wire logic cmd_ack,
  output logic [1:0] test_status
);

  localparam int N = tap_port_pkg::BSR_LEN;
  localparam int G = tap_port_pkg::GROUPS;

  // refuse values that the counters and the chain layout cannot serve
  if (TIMEOUT_CYCLES < 2 || SYSCLK_DIV < 1 || N <= tap_port_pkg::SNIFFER_POS) begin : g_bad_param
    $error("boundary_scan_test_port: unsupported parameter values");
  end

  // two-flop synchronisers for the test pins, oscillator sense, command handshake and system reset
  logic [7:0] sync1_q;
  logic [7:0] sync2_q;
  logic tck_d2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
      tck_d2_q <= 1'b0;
    end else begin
      sync1_q <= {tap_pins.tck, tap_pins.tms, tap_pins.tdi, tap_pins.trst_n,
                  osc_present, cmd_fail, cmd_ack, sys_reset_n};
      sync2_q <= sync1_q;
      tck_d2_q <= sync2_q[7];
    end
  end

  logic tck_s, tms_s, tdi_s, trst_n_s, osc_s, fail_s, ack_s, sysrst_n_s;
  assign {tck_s, tms_s, tdi_s, trst_n_s, osc_s, fail_s, ack_s, sysrst_n_s} = sync2_q;
  logic tck_rise, tck_fall, test_enable, tap_hold;
  assign tck_rise = tck_s & ~tck_d2_q;
  assign tck_fall = ~tck_s & tck_d2_q;
  // factory modes or missing power leave the test logic parked
  assign test_enable = (port_mode == 2'b00) && power_good_input; // RL22
  // an undriven test reset reads low through its pad pull-down and parks the machine
  assign tap_hold = ~trst_n_s | ~test_enable; // RL23

  // tap state machine
  tap_port_pkg::tap_state_type tap_q, tap_d;
  always_comb begin
    tap_d = tap_q;
    case (tap_q)
      tap_port_pkg::st_reset: tap_d = tms_s ? tap_port_pkg::st_reset : tap_port_pkg::st_idle;
      tap_port_pkg::st_idle: tap_d = tms_s ? tap_port_pkg::st_sel_dr : tap_port_pkg::st_idle;
      tap_port_pkg::st_sel_dr: tap_d = tms_s ? tap_port_pkg::st_sel_ir
                                             : tap_port_pkg::st_cap_dr;
      tap_port_pkg::st_cap_dr: tap_d = tms_s ? tap_port_pkg::st_exit1_dr
                                             : tap_port_pkg::st_shift_dr;
      tap_port_pkg::st_shift_dr: tap_d = tms_s ? tap_port_pkg::st_exit1_dr
                                               : tap_port_pkg::st_shift_dr;
      tap_port_pkg::st_exit1_dr: tap_d = tms_s ? tap_port_pkg::st_upd_dr
                                               : tap_port_pkg::st_pause_dr;
      tap_port_pkg::st_pause_dr: tap_d = tms_s ? tap_port_pkg::st_exit2_dr
                                               : tap_port_pkg::st_pause_dr;
      tap_port_pkg::st_exit2_dr: tap_d = tms_s ? tap_port_pkg::st_upd_dr
                                               : tap_port_pkg::st_shift_dr;
      tap_port_pkg::st_upd_dr: tap_d = tms_s ? tap_port_pkg::st_sel_dr : tap_port_pkg::st_idle;
      tap_port_pkg::st_sel_ir: tap_d = tms_s ? tap_port_pkg::st_reset : tap_port_pkg::st_cap_ir;
      tap_port_pkg::st_cap_ir: tap_d = tms_s ? tap_port_pkg::st_exit1_ir
                                             : tap_port_pkg::st_shift_ir;
      tap_port_pkg::st_shift_ir: tap_d = tms_s ? tap_port_pkg::st_exit1_ir
                                               : tap_port_pkg::st_shift_ir;
      tap_port_pkg::st_exit1_ir: tap_d = tms_s ? tap_port_pkg::st_upd_ir
                                               : tap_port_pkg::st_pause_ir;
      tap_port_pkg::st_pause_ir: tap_d = tms_s ? tap_port_pkg::st_exit2_ir
                                               : tap_port_pkg::st_pause_ir;
      tap_port_pkg::st_exit2_ir: tap_d = tms_s ? tap_port_pkg::st_upd_ir
                                               : tap_port_pkg::st_shift_ir;
      tap_port_pkg::st_upd_ir: tap_d = tms_s ? tap_port_pkg::st_sel_dr : tap_port_pkg::st_idle;
      default: tap_d = tap_port_pkg::st_reset;
    endcase
  end

  // state advances on each test clock rising edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tap_q <= tap_port_pkg::st_reset;
    end else if (tap_hold) begin
      tap_q <= tap_port_pkg::st_reset; // RL24
    end else if (tck_rise) begin
      tap_q <= tap_d; // RL15 RL24
    end
  end

  // one-cycle controls for the selected chain
  logic cap_dr, sh_dr, upd_dr, cap_ir, sh_ir, upd_ir;
  assign cap_dr = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_cap_dr; // RL15
  assign sh_dr = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_shift_dr;
  assign upd_dr = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_upd_dr;
  assign cap_ir = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_cap_ir;
  assign sh_ir = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_shift_ir;
  assign upd_ir = tck_rise && !tap_hold && tap_q == tap_port_pkg::st_upd_ir;

  // instruction chain: shift stage and held instruction
  logic [tap_port_pkg::IR_WIDTH-1:0] ir_shift_q, ir_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ir_shift_q <= tap_port_pkg::IR_CAPTURE;
      ir_q <= tap_port_pkg::IR_BYPASS;
    end else if (tap_hold || tap_q == tap_port_pkg::st_reset) begin
      ir_q <= tap_port_pkg::IR_BYPASS; // RL7
    end else if (cap_ir) begin
      ir_shift_q <= tap_port_pkg::IR_CAPTURE; // RL2
    end else if (sh_ir) begin
      ir_shift_q <= {tdi_s, ir_shift_q[tap_port_pkg::IR_WIDTH-1:1]}; // RL1
    end else if (upd_ir) begin
      ir_q <= ir_shift_q; // RL1
    end
  end

  // instruction decode; every unlisted code falls back to the skip chain
  logic sel_bsr, sel_id, drive_cells, float_all;
  assign sel_bsr = ir_q == tap_port_pkg::IR_EXTEST || ir_q == tap_port_pkg::IR_SAMPLE
                   || ir_q == tap_port_pkg::IR_PRIV_BSR; // RL3 RL4 RL9
  assign sel_id = ir_q == tap_port_pkg::IR_ID_A || ir_q == tap_port_pkg::IR_ID_B; // RL7
  assign drive_cells = ir_q == tap_port_pkg::IR_EXTEST
                       || ir_q == tap_port_pkg::IR_CLAMP; // RL3 RL5
  assign float_all = ir_q == tap_port_pkg::IR_HIGHZ; // RL6

  // single-stage skip chain and identification chain
  logic skip_q;
  logic [tap_port_pkg::ID_LEN-1:0] id_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      skip_q <= 1'b0;
      id_q <= '0;
    end else if (!sel_bsr && !sel_id) begin
      if (cap_dr) begin
        skip_q <= 1'b0;
      end else if (sh_dr) begin
        skip_q <= tdi_s; // RL8
      end
    end else if (sel_id) begin
      if (cap_dr) begin
        id_q <= ID_VALUE;
      end else if (sh_dr) begin
        id_q <= {tdi_s, id_q[tap_port_pkg::ID_LEN-1:1]};
      end
    end
  end

  // boundary chain capture: the sniffer replaces cell 255, oscillator pins have no cells
  logic [N-1:0] capture_vec;
  always_comb begin
    capture_vec = pin_in;
    capture_vec[tap_port_pkg::SNIFFER_POS] = osc_s; // RL13 RL14
  end

  // boundary chain shift stage and update latches
  logic [N-1:0] bsr_q, bsr_upd_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bsr_q <= '0;
      bsr_upd_q <= '0;
    end else if (sel_bsr) begin
      if (cap_dr) begin
        bsr_q <= capture_vec; // RL4 RL13
      end else if (sh_dr) begin
        bsr_q <= {tdi_s, bsr_q[N-1:1]}; // RL9 RL10
      end else if (upd_dr) begin
        bsr_upd_q <= bsr_q; // RL4
      end
    end
  end

  // tdo changes on the test clock falling edge, driven only while shifting
  logic tdo_q, tdo_oe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tdo_q <= 1'b0;
      tdo_oe_q <= 1'b0;
    end else if (tap_hold) begin
      tdo_oe_q <= 1'b0;
    end else if (tck_fall) begin
      tdo_oe_q <= tap_q == tap_port_pkg::st_shift_ir || tap_q == tap_port_pkg::st_shift_dr;
      if (tap_q == tap_port_pkg::st_shift_ir) begin
        tdo_q <= ir_shift_q[0];
      end else if (sel_bsr) begin
        tdo_q <= bsr_q[0]; // RL10
      end else if (sel_id) begin
        tdo_q <= id_q[0];
      end else begin
        tdo_q <= skip_q; // RL8
      end
    end
  end
  assign tdo = tdo_q;
  assign tdo_oe = tdo_oe_q;

  // per-group enables: under extest or clamp, a 1 in the group's control cell floats its drivers
  logic [G-1:0] group_oe_d;
  genvar gi;
  generate
    for (gi = 0; gi < G; gi++) begin : g_group
      assign group_oe_d[gi] = float_all ? 1'b0 // RL6
                            : drive_cells
                            ? ~bsr_upd_q[tap_port_pkg::GROUP_CTRL_POS[gi]] // RL11 RL12
                            : core_group_oe[gi];
    end
  endgenerate

  // pad drive is registered; data words follow their group cells like any other pin
  logic [N-1:0] pin_out_q;
  logic [G-1:0] group_oe_q;
  logic outputs_oe_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= '0;
      group_oe_q <= '0;
      outputs_oe_q <= 1'b0;
    end else begin
      pin_out_q <= drive_cells ? bsr_upd_q : core_out; // RL3 RL5 RL16
      group_oe_q <= group_oe_d;
      outputs_oe_q <= ~float_all; // RL6
    end
  end
  assign pin_out = pin_out_q;
  assign group_oe = group_oe_q;
  assign outputs_oe = outputs_oe_q;

  // sysclk edge enable from a divider on pclk
  logic [15:0] div_q;
  logic sys_tick;
  assign sys_tick = div_q == 16'(SYSCLK_DIV - 1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= '0;
    end else begin
      div_q <= sys_tick ? 16'h0000 : div_q + 16'h0001;
    end
  end

  // retire watchdog and fail-without-ack detection
  logic [31:0] idle_cnt_q;
  logic timeout_event;
  assign timeout_event = idle_cnt_q == 32'(TIMEOUT_CYCLES - 1) || (fail_s && !ack_s); // RL20
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idle_cnt_q <= '0;
    end else if (!sysrst_n_s || retire || timeout_event) begin
      idle_cnt_q <= '0;
    end else begin
      idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end
  end

  // pulse starts and ends on sysclk ticks, so it lasts at least 256 cycles
  logic pend_q, pulse_q;
  logic [8:0] pulse_cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= 1'b0;
      pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else if (!sysrst_n_s) begin
      pend_q <= 1'b0;
      pulse_q <= 1'b0;
      pulse_cnt_q <= '0;
    end else begin
      if (timeout_event && !pulse_q) begin
        pend_q <= 1'b1;
      end else if (pend_q && sys_tick) begin
        pend_q <= 1'b0;
      end
      if (pend_q && sys_tick && !pulse_q) begin
        pulse_q <= 1'b1; // RL21
        pulse_cnt_q <= '0;
      end else if (pulse_q) begin
        if (pulse_cnt_q < 9'(tap_port_pkg::PULSE_CYCLES)) begin
          pulse_cnt_q <= pulse_cnt_q + 9'h001;
        end else if (sys_tick) begin
          pulse_q <= 1'b0; // RL21
        end
      end
    end
  end

  // self-test status: start wins over a same-cycle completion
  logic built_in_selftest_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      built_in_selftest_q <= 1'b0;
    end else if (!sysrst_n_s) begin
      built_in_selftest_q <= 1'b0; // RL17
    end else if (selftest_start) begin
      built_in_selftest_q <= 1'b1; // RL18
    end else if (selftest_done && selftest_pass) begin
      built_in_selftest_q <= 1'b0; // RL18
    end
  end

  // apb: setup phase latches read data, access phase always completes at once
  logic sw_status1_q;
  logic [31:0] rdata_q;
  logic err_q;
  logic setup, wr_ok;
  assign setup = psel && !penable;
  assign wr_ok = psel && penable && pwrite && !err_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q <= 1'b0;
    end else if (setup) begin
      rdata_q <= '0;
      err_q <= 1'b0;
      if (paddr == tap_port_pkg::CTRL_OFS) begin
        rdata_q[tap_port_pkg::CTRL_STATUS1_BIT] <= sw_status1_q;
      end else if (paddr == tap_port_pkg::STAT_OFS) begin
        rdata_q[tap_port_pkg::STAT_SELFTEST_BIT] <= built_in_selftest_q; // RL19
        rdata_q[tap_port_pkg::STAT_PULSE_BIT] <= pulse_q;
        rdata_q[tap_port_pkg::STAT_ENABLE_BIT] <= test_enable;
        rdata_q[tap_port_pkg::STAT_STATE_LSB +: 4] <= tap_q;
        rdata_q[tap_port_pkg::STAT_IR_LSB +: tap_port_pkg::IR_WIDTH] <= ir_q;
      end else begin
        err_q <= 1'b1; // unmapped address
      end
    end
  end

  // software-written value for status pin 1
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_status1_q <= 1'b0;
    end else if (!sysrst_n_s) begin
      sw_status1_q <= 1'b0; // RL17
    end else if (wr_ok && paddr == tap_port_pkg::CTRL_OFS) begin
      sw_status1_q <= pwdata[tap_port_pkg::CTRL_STATUS1_BIT]; // RL19
    end
  end
  assign prdata = rdata_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && err_q;
  assign test_status = {sw_status1_q | pulse_q, built_in_selftest_q};

  // checks
  logic [2:0] ones_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ones_q <= '0;
    end else if (tck_rise) begin
      ones_q <= !tms_s ? 3'h0 : (ones_q == 3'h7 ? ones_q : ones_q + 3'h1);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ir_capture_s;
    cap_ir ##1 1'b1;
  endsequence
  ir_capture_load_a: assert property (ir_capture_s |-> ir_shift_q == tap_port_pkg::IR_CAPTURE) // RL2
    else $error("capture-ir did not load 00001");
  tms_reset_a: assert property (ones_q >= 3'(tap_port_pkg::TLR_ONES)
                                |-> tap_q == tap_port_pkg::st_reset) // RL24
    else $error("five tms ones did not reach reset");
  bypass_default_a: assert property (tap_q == tap_port_pkg::st_reset |=> ir_q == 5'h1f) // RL7
    else $error("reset state did not restore bypass");
  highz_float_a: assert property (float_all |=> !outputs_oe && group_oe == '0) // RL6
    else $error("highz left a driver on");
  extest_drive_a: assert property (ir_q == tap_port_pkg::IR_EXTEST ##1 ir_q == tap_port_pkg::IR_EXTEST
                                   |-> pin_out == $past(bsr_upd_q)) // RL3
    else $error("extest pins not from cells");
  sample_pass_a: assert property (ir_q == 5'h02 |=> pin_out == $past(core_out)) // RL4
    else $error("sample disturbed pin drive");
  status_reset_a: assert property (!sysrst_n_s ##1 !sysrst_n_s |-> test_status == 2'b00) // RL17
    else $error("status pins not low in reset");
  sequence pulse_start_s;
    !pulse_q ##1 pulse_q;
  endsequence
  pulse_width_a: assert property (pulse_start_s |-> pulse_q[*8] ##0 $past(sys_tick, 8)) // RL21
    else $error("timeout pulse did not start on sysclk tick");
  pulse_min_a: assert property ($fell(pulse_q) && sysrst_n_s |-> pulse_cnt_q == 9'h100) // RL21
    else $error("timeout pulse shorter than 256 cycles");
  built_in_selftest_start_a: assert property (selftest_start && sysrst_n_s |=> test_status[0]) // RL18
    else $error("self-test start did not raise status0");
  skip_shift_a: assert property (sh_dr && !sel_bsr && !sel_id |=> skip_q == $past(tdi_s)) // RL8
    else $error("skip chain did not take tdi");

endmodule : boundary_scan_test_port

// >>> jtag_tester.sv
// behavioural boundary-scan tester driving the test port pins
`timescale 1ns/1ps
module jtag_tester (
  input wire logic pclk,
  output tap_port_pkg::tap_pins_type pins,
  input wire logic tdo
);
  // port held in reset until released; tck rests low outside frames
  initial pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b0, trst_n: 1'b0};
  // one tck period; tdi inverted once used, as nothing pulls it
  task automatic step(input logic ms, input logic di, output logic dq);
    pins.tms = ms;
    pins.tdi = di;
    #80 dq = tdo;
    pins.tck = 1'b1;
    #40 pins.tdi = ~di; // mid high phase, long after the synced rise took it
    #40 pins.tck = 1'b0;
  endtask : step
  // test reset pin level
  task automatic set_trst(input logic v);
    @(negedge pclk);
    pins.trst_n = v;
  endtask : set_trst
  // five tms ones reach test logic reset, then park in idle
  task automatic five_ones();
    logic d;
    @(negedge pclk); // frames start off the pclk sampling edge
    repeat (5) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask : five_ones
  // from idle: capture, shift n bits lsb first, update, back to idle
  task automatic scan(input logic ir, input int n, input logic [579:0] din,
                      output logic [579:0] dout);
    logic d;
    dout = '0;
    @(negedge pclk);
    step(1'b1, 1'b0, d);
    if (ir) step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
    step(1'b0, 1'b0, d);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], dout[i]);
    step(1'b1, 1'b0, d);
    step(1'b0, 1'b0, d);
  endtask : scan
endmodule : jtag_tester

// >>> tb.sv
// self-checking bench for the boundary-scan test port
`timescale 1ns/1ps
module tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] port_mode = 2'h0;
  logic power_good_input = 1'b1, osc_present = 1'b1, sys_reset_n = 1'b1;
  logic [288:0] pin_in = {{144{2'b10}}, 1'b1};
  logic [288:0] core_out = {{144{2'b01}}, 1'b0};
  logic [6:0] core_group_oe = 7'h55;
  logic selftest_start = 1'b0, selftest_done = 1'b0, selftest_pass = 1'b0;
  logic retire = 1'b1, cmd_fail = 1'b0, cmd_ack = 1'b0;
  wire tap_port_pkg::tap_pins_type tap_pins;
  logic [31:0] prdata, rd;
  logic pready, pslverr, tdo, tdo_oe, outputs_oe, err;
  logic [288:0] pin_out;
  logic [6:0] group_oe;
  logic [6:0] gpat = 7'h53;
  logic [1:0] test_status;
  logic [579:0] din, dout;
  int bad_count = 0, n_checks = 0, k, n;
  // instruction rows: code beside the chain length it selects
  logic [4:0] codes [11] = '{5'h00, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h1e,
    5'h1f, 5'h01};
  int lens [11] = '{289, 289, 289, 1, 1, 32, 32, 1, 1, 1, 1};

  boundary_scan_test_port #(.TIMEOUT_CYCLES(300)) i_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .tap_pins, .tdo, .tdo_oe, .port_mode, .power_good_input, .osc_present, .pin_in, .core_out,
    .core_group_oe, .pin_out, .group_oe, .outputs_oe, .sys_reset_n, .selftest_start,
    .selftest_done, .selftest_pass, .retire, .cmd_fail, .cmd_ack, .test_status
  );
  jtag_tester i_tester (.pclk, .pins(tap_pins), .tdo);

  // 125 MHz system clock
  always #4 pclk = ~pclk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : results

  // a wait that ran out ends the run
  task automatic give_up();
    bad_count++;
    $display("unexpected at %0t: wait ran out", $time);
    results();
  endtask : give_up

  // idle gap first so earlier changes have settled before the setup cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    repeat (4) @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) give_up();
  endtask : apb

  // cycles until status pin 1 shows v
  task automatic wait_st1(input logic v, input int lim);
    k = 0;
    while (test_status[1] !== v && k < lim) begin
      @(posedge pclk);
      k++;
    end
    if (test_status[1] !== v) give_up();
  endtask : wait_st1

  // one-cycle self-test event, then a short settle
  task automatic st_pulse(input logic s, input logic d, input logic p);
    @(posedge pclk);
    selftest_start <= s;
    selftest_done <= d;
    selftest_pass <= p;
    @(posedge pclk);
    selftest_start <= 1'b0;
    selftest_done <= 1'b0;
    selftest_pass <= 1'b0;
    repeat (4) @(posedge pclk);
  endtask : st_pulse

  initial begin
    repeat (20) @(posedge pclk);
    check({tdo_oe, outputs_oe, group_oe, test_status, pin_out[7:0]}, 32'h0);
    presetn <= 1'b1;
    i_tester.set_trst(1'b1);
    i_tester.five_ones();
    $display("reset test done");
    // per code: capture pattern, chain length, captured contents
    for (int r = 0; r < 11; r++) begin
      i_tester.scan(1'b1, 5, 580'(codes[r]), dout);
      check(dout[4:0], 5'h01);
      n = lens[r];
      din = '0;
      din[n] = 1'b1;
      i_tester.scan(1'b0, 2 * n + 1, din, dout);
      check({dout[2 * n], dout[2 * n - 1]}, 2'b10);
      check(outputs_oe, codes[r] != tap_port_pkg::IR_HIGHZ);
      if (n == 289) check({dout[255], dout[1], dout[0]}, 3'b101);
      if (n == 32) check(dout[31:0], tap_port_pkg::ID_VALUE);
      $display("code %h test done", codes[r]);
    end
    // preload group controls and two data cells, then each drive mode
    din = '0;
    for (int g = 0; g < 7; g++) din[tap_port_pkg::GROUP_CTRL_POS[g]] = gpat[g];
    din[225] = 1'b1;
    din[0] = 1'b1;
    i_tester.scan(1'b1, 5, 580'(tap_port_pkg::IR_SAMPLE), dout);
    i_tester.scan(1'b0, 289, din, dout);
    check({group_oe, pin_out[1:0]}, {core_group_oe, core_out[1:0]});
    i_tester.scan(1'b1, 5, 580'(tap_port_pkg::IR_EXTEST), dout);
    check({group_oe, pin_out[225], pin_out[0]}, {~gpat, 2'b11});
    i_tester.scan(1'b1, 5, 580'(tap_port_pkg::IR_HIGHZ), dout);
    check({outputs_oe, group_oe}, 8'h00);
    i_tester.scan(1'b1, 5, 580'(tap_port_pkg::IR_CLAMP), dout);
    check({outputs_oe, group_oe, pin_out[225]}, {1'b1, ~gpat, 1'b1});
    $display("pin drive test done");
    // tms ones, test reset and a factory port mode all force reset
    i_tester.five_ones();
    apb(1'b0, tap_port_pkg::STAT_OFS, 32'h0);
    check({rd[12:4], rd[2]}, {5'h1f, 4'h1, 1'b1});
    i_tester.scan(1'b1, 5, 580'(tap_port_pkg::IR_EXTEST), dout);
    i_tester.set_trst(1'b0);
    apb(1'b0, tap_port_pkg::STAT_OFS, 32'h0);
    check(rd[12:4], {5'h1f, 4'h0});
    i_tester.set_trst(1'b1);
    port_mode <= 2'b01;
    apb(1'b0, tap_port_pkg::STAT_OFS, 32'h0);
    check({rd[7:4], rd[2]}, 5'h00);
    port_mode <= 2'b00;
    power_good_input <= 1'b0;
    apb(1'b0, tap_port_pkg::STAT_OFS, 32'h0);
    check({rd[7:4], rd[2]}, 5'h00);
    power_good_input <= 1'b1;
    $display("tap reset test done");
    // software status value, read back, refused address
    apb(1'b1, tap_port_pkg::CTRL_OFS, 32'h1);
    apb(1'b0, tap_port_pkg::CTRL_OFS, 32'h0);
    check({test_status[1], err}, 2'b10);
    check(rd, 32'h1);
    apb(1'b1, 8'h08, 32'h1);
    check(err, 1'b1);
    apb(1'b0, 8'h08, 32'h0);
    check(err, 1'b1);
    check(rd, 32'h0);
    apb(1'b1, tap_port_pkg::CTRL_OFS, 32'h0);
    // self-test: failure holds the pin, pass clears it
    st_pulse(1'b1, 1'b0, 1'b0);
    check(test_status, 2'b01);
    st_pulse(1'b0, 1'b1, 1'b0);
    check(test_status[0], 1'b1);
    st_pulse(1'b1, 1'b0, 1'b0);
    st_pulse(1'b0, 1'b1, 1'b1);
    check(test_status[0], 1'b0);
    st_pulse(1'b1, 1'b0, 1'b0);
    apb(1'b0, tap_port_pkg::STAT_OFS, 32'h0);
    check(rd[0], 1'b1);
    $display("status pin test done");
    // retire stall, then fail without acknowledge, each give one pulse
    retire <= 1'b0;
    wait_st1(1'b1, 400);
    check(k >= 290 && k <= 320, 1'b1);
    wait_st1(1'b0, 300);
    check(k >= 256 && k <= 260, 1'b1);
    retire <= 1'b1;
    cmd_fail <= 1'b1;
    cmd_ack <= 1'b1;
    repeat (40) @(posedge pclk);
    check(test_status[1], 1'b0);
    cmd_ack <= 1'b0;
    wait_st1(1'b1, 20);
    cmd_fail <= 1'b0;
    wait_st1(1'b0, 300);
    check(k >= 256 && k <= 260, 1'b1);
    // system reset clears both pins
    apb(1'b1, tap_port_pkg::CTRL_OFS, 32'h1);
    sys_reset_n <= 1'b0;
    repeat (6) @(posedge pclk);
    check(test_status, 2'b00);
    sys_reset_n <= 1'b1;
    $display("timeout test done");
    results();
  end
endmodule : tb
